/* File: srb_params.svh */
/*
  Constants for the two-word burst DDR SRAM port: widths, lane size,
  buffer depth and clock rate.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef SRB_PARAMS_SVH
`define SRB_PARAMS_SVH

// Default organisation: 36-bit words, 20 address bits
`define SRB_DATA_W     36
`define SRB_ADDR_W     20
// One byte write select governs one 9-bit lane
`define SRB_LANE_W     9
// Read buffer between array and output launch
`define SRB_BUF_DEPTH  2
// Words per burst
`define SRB_BURST_LEN  2
// Fabric clock rate
`define SRB_CLK_MHZ    40

`endif

/* File: srb_pkg.sv */
/*
  Types shared by the burst SRAM port modules.
  Assumes srb_params.svh is on the include path.
*/
`default_nettype none
`include "srb_params.svh"

package srb_pkg;

  // Gray codes along each burst path
  typedef enum logic [2:0] {
    SRB_IDLE  = 3'h0,
    SRB_WR_B0 = 3'h1,
    SRB_WR_B1 = 3'h3,
    SRB_RD_W0 = 3'h4,
    SRB_RD_W1 = 3'h6
  } srb_state_t;

  // Clock and control pins, carried together through the synchroniser
  typedef struct packed {
    logic k;
    logic k_n;
    logic c;
    logic c_n;
    logic load_n;
    logic rw;
    logic pll_disable_n;
    logic single_clock;
  } srb_ctl_t;

endpackage

`default_nettype wire

/* File: srb_sync2.sv */
/*
  Two-flop synchroniser for a vector of pin inputs.
  Assumes the pins are quasi-static relative to clk; no bus coherence.
*/
`timescale 1ns/1ps
`default_nettype none

module srb_sync2 #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta;

  // First stage is read by the second stage only
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      meta <= '0;
      dout <= '0;
    end
    else if (ce)
    begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

`default_nettype wire

/* File: srb_buf2.sv */
/*
  Small valid/ready FIFO, default two entries, for read words.
  Assumes DEPTH is a power of two; same clock on both sides.
*/
`timescale 1ns/1ps
`default_nettype none

module srb_buf2 #(
  parameter int W     = 36,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  slot [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0]   count;
  logic          push;
  logic          pop;

  assign in_ready  = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = slot[rd_ptr];
  assign push      = ce & in_valid & in_ready;
  assign pop       = ce & out_valid & out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
      slot[wr_ptr] <= in_data;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end

endmodule

`default_nettype wire

/* File: srb_port.sv */
/*
  Two-word burst DDR SRAM port: pin capture, burst sequencer, byte-lane
  array, read buffer and output launch with echo strobes.
  Assumes all pins, including the data clocks, are slow against clk and
  are sampled through two flops; the data bus tristate is resolved outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "srb_params.svh"

module srb_port #(
  parameter int DATA_W = `SRB_DATA_W,
  parameter int ADDR_W = `SRB_ADDR_W
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              ce,
  input  wire logic              k_in,
  input  wire logic              k_n_in,
  input  wire logic              c_in,
  input  wire logic              c_n_in,
  input  wire logic              load_n,
  input  wire logic              rw,
  input  wire logic              pll_disable_n,
  input  wire logic              single_clock,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W/`SRB_LANE_W-1:0] byte_write_select_n,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic      [DATA_W-1:0] dq_out,
  output logic                   dq_oe,
  output logic                   echo_strobe,
  output logic                   echo_strobe_n
);

  localparam int LANE_W = `SRB_LANE_W;
  localparam int LANES  = DATA_W / LANE_W;
  localparam int ROW_W  = ADDR_W - 1;
  localparam int DEPTH  = 2 ** ROW_W;
  localparam int CTL_W  = $bits(srb_pkg::srb_ctl_t);
  localparam int SYN_W  = CTL_W + LANES + ADDR_W + DATA_W;

  ////////////////////////////////////////////////////////////////////////
  // Pin capture

  srb_pkg::srb_ctl_t     ctl_pins;
  srb_pkg::srb_ctl_t     ctl_s;
  logic [LANES-1:0]      lane_sel_s;
  logic [ADDR_W-1:0]     addr_s;
  logic [DATA_W-1:0]     dq_s;
  logic [SYN_W-1:0]      syn_out;

  assign ctl_pins = '{k: k_in, k_n: k_n_in, c: c_in, c_n: c_n_in,
                      load_n: load_n, rw: rw, pll_disable_n: pll_disable_n,
                      single_clock: single_clock};

  // Selects ride with their data through the same flops
  srb_sync2 #(
    .W (SYN_W)
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .din   ({ctl_pins, byte_write_select_n, addr, dq_in}),
    .dout  (syn_out)
  );

  assign {ctl_s, lane_sel_s, addr_s, dq_s} = syn_out;

  logic k_q;
  logic k_n_q;
  logic c_q;
  logic c_n_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      k_q   <= 1'b0;
      k_n_q <= 1'b0;
      c_q   <= 1'b0;
      c_n_q <= 1'b0;
    end
    else if (ce)
    begin
      k_q   <= ctl_s.k;
      k_n_q <= ctl_s.k_n;
      c_q   <= ctl_s.c;
      c_n_q <= ctl_s.c_n;
    end
  end

  logic k_rise;
  logic kn_rise;
  logic c_rise;
  logic cn_rise;

  assign k_rise  = ce & ctl_s.k & ~k_q;
  assign kn_rise = ce & ctl_s.k_n & ~k_n_q;
  assign c_rise  = ce & ctl_s.c & ~c_q;
  assign cn_rise = ce & ctl_s.c_n & ~c_n_q;

  ////////////////////////////////////////////////////////////////////////
  // Burst sequencer

  srb_pkg::srb_state_t state;
  srb_pkg::srb_state_t next_state;
  logic [ROW_W-1:0]    row;
  logic                seed;
  logic                take_cycle;
  logic                buf_in_ready;
  logic                buf_in_valid;

  // Address is looked at only here, so a deselected port ignores it
  assign take_cycle = k_rise & ~ctl_s.load_n;

  always_comb
  begin
    next_state = state;
    case (state)
      srb_pkg::SRB_IDLE:
        if (take_cycle)
          next_state = ctl_s.rw ? srb_pkg::SRB_RD_W0 : srb_pkg::SRB_WR_B0;
      srb_pkg::SRB_WR_B0:
        if (k_rise)
          next_state = srb_pkg::SRB_WR_B1;
      srb_pkg::SRB_WR_B1:
        if (kn_rise)
          next_state = srb_pkg::SRB_IDLE;
      srb_pkg::SRB_RD_W0:
        if (ce && buf_in_ready)
          next_state = srb_pkg::SRB_RD_W1;
      srb_pkg::SRB_RD_W1:
        if (ce && buf_in_ready)
          next_state = srb_pkg::SRB_IDLE;
      default:
        next_state = srb_pkg::SRB_IDLE;
    endcase
  end

  // Loads seen mid-burst are dropped; the burst runs out first
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      state <= srb_pkg::SRB_IDLE;
    else if (ce)
      state <= next_state;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      row  <= '0;
      seed <= 1'b0;
    end
    else if (state == srb_pkg::SRB_IDLE && take_cycle)
    begin
      row  <= addr_s[ADDR_W-1:1];
      seed <= addr_s[0];
    end
  end

  logic second_word;
  logic bank;

  assign second_word = (state == srb_pkg::SRB_WR_B1) || (state == srb_pkg::SRB_RD_W1);
  assign bank        = second_word ? ~seed : seed;
  assign buf_in_valid = (state == srb_pkg::SRB_RD_W0) || (state == srb_pkg::SRB_RD_W1);

  ////////////////////////////////////////////////////////////////////////
  // Array: two banks split on the burst bit, one slice per lane

  logic              wr_en;
  logic [DATA_W-1:0] rd_word;

  assign wr_en = (state == srb_pkg::SRB_WR_B0 && k_rise) ||
                 (state == srb_pkg::SRB_WR_B1 && kn_rise);

  // Width and depth follow ADDR_W and DATA_W, so both organisations fit
  generate
    for (genvar l = 0; l < LANES; l++)
    begin : g_lane
      logic [LANE_W-1:0] bank_even [DEPTH];
      logic [LANE_W-1:0] bank_odd  [DEPTH];

      always_ff @(posedge clk)
      begin
        if (wr_en && !lane_sel_s[l])
        begin
          if (bank)
            bank_odd[row]  <= dq_s[l*LANE_W +: LANE_W];
          else
            bank_even[row] <= dq_s[l*LANE_W +: LANE_W];
        end
      end

      assign rd_word[l*LANE_W +: LANE_W] = bank ? bank_odd[row] : bank_even[row];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Read buffer and output launch

  logic              buf_out_valid;
  logic [DATA_W-1:0] buf_out_data;
  logic              true_edge;
  logic              comp_edge;
  logic              await_comp;
  logic              next_comp;
  logic              at_edge;

  // Launch stalls the sequencer through the buffer, no word is lost
  srb_buf2 #(
    .W     (DATA_W),
    .DEPTH (`SRB_BUF_DEPTH)
  ) u_buf (
    .clk       (clk),
    .reset     (reset),
    .ce        (ce),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (rd_word),
    .out_valid (buf_out_valid),
    .out_ready (at_edge),
    .out_data  (buf_out_data)
  );

  assign true_edge = ctl_s.single_clock ? k_rise : c_rise;
  assign comp_edge = ctl_s.single_clock ? kn_rise : cn_rise;
  // DDR-I starts on a true edge, otherwise on a complement edge, half a cycle earlier
  assign await_comp = dq_oe ? next_comp : ctl_s.pll_disable_n;
  assign at_edge    = await_comp ? comp_edge : true_edge;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      dq_out    <= '0;
      dq_oe     <= 1'b0;
      next_comp <= 1'b0;
    end
    else if (at_edge)
    begin
      if (buf_out_valid)
      begin
        dq_out    <= buf_out_data;
        dq_oe     <= 1'b1;
        next_comp <= ~await_comp;
      end
      else
        dq_oe <= 1'b0;
    end
  end

  // Echo strobes run free, even between bursts
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      echo_strobe   <= 1'b0;
      echo_strobe_n <= 1'b0;
    end
    else if (ce)
    begin
      echo_strobe   <= ctl_s.single_clock ? ctl_s.k : ctl_s.c;
      echo_strobe_n <= ctl_s.single_clock ? ctl_s.k_n : ctl_s.c_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_read_load;
    state == srb_pkg::SRB_IDLE && take_cycle && ctl_s.rw;
  endsequence

  sequence s_write_load;
    state == srb_pkg::SRB_IDLE && take_cycle && !ctl_s.rw;
  endsequence

  a_write_beat_order: assert property (
    (state == srb_pkg::SRB_WR_B0 && k_rise) |=> state == srb_pkg::SRB_WR_B1)
    else $error("write beat one not followed by beat two wait");

  a_launch_word: assert property (
    (at_edge && buf_out_valid) |=> dq_oe && dq_out == $past(buf_out_data))
    else $error("read word not launched on its edge");

  a_single_edge: assert property (
    (ctl_s.single_clock && !await_comp && buf_out_valid && k_rise) |=> dq_oe)
    else $error("single clock mode did not launch on true input clock");

  a_oe_release: assert property (
    (at_edge && !buf_out_valid) |=> !dq_oe)
    else $error("output enable held with no read word");

  a_load_taken: assert property (
    s_write_load |=> state == srb_pkg::SRB_WR_B0 && seed == $past(addr_s[0]))
    else $error("write cycle not latched");

  a_read_dir: assert property (
    s_read_load |=> state == srb_pkg::SRB_RD_W0 ##[1:40] state == srb_pkg::SRB_IDLE)
    else $error("read burst did not start or finish");

  a_burst_bank: assert property (
    (state == srb_pkg::SRB_RD_W0 && ce && buf_in_ready) |=> bank != $past(bank))
    else $error("second word did not flip the burst bit");

  a_idle_hold: assert property (
    (state == srb_pkg::SRB_IDLE && !take_cycle) |=> state == srb_pkg::SRB_IDLE)
    else $error("transaction started without load");

  a_echo_follow: assert property (
    ce |=> echo_strobe == $past(ctl_s.single_clock ? ctl_s.k : ctl_s.c))
    else $error("echo strobe does not follow its clock");

endmodule

`default_nettype wire

/* File: srb_ctrl_model.sv */
/*
  Memory controller model facing the burst SRAM port: input clocks, output
  clocks, load strobe, direction, address, byte selects and write data.
  Assumes the bench calls phase() just after a clk rise; k stands still
  between calls, and the c pair stands still in single clock mode.
*/
`timescale 1ns/1ps
`default_nettype none
`include "srb_params.svh"

module srb_ctrl_model (
  input  wire logic                    clk,
  input  wire logic                    single_clock,
  output logic                         k,
  output logic                         k_n,
  output logic                         c,
  output logic                         c_n,
  output logic                         load_n,
  output logic                         rw,
  output logic [`SRB_ADDR_W-1:0]       addr,
  output logic [`SRB_DATA_W/9-1:0]     byte_write_select_n,
  output logic [`SRB_DATA_W-1:0]       dq_in
);
  initial
  begin
    k = 1'b0;
    k_n = 1'b1;
    c = 1'b0;
    c_n = 1'b1;
    load_n = 1'b1;
    rw = 1'b0;
    addr = 20'h00000;
    byte_write_select_n = 4'hf;
    dq_in = 36'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One half period: qualifiers settle 4 clk before the edge, held 6 after,
  // since every pin crosses two sync flops
  task automatic phase(input logic kv, input logic lstb, input logic r,
                       input logic [19:0] a, input logic [35:0] d,
                       input logic [3:0] b);
    load_n = lstb;
    rw = r;
    // Unused lines carry junk so a stale value cannot pass for a good one
    addr = lstb ? ~addr : a;
    dq_in = (b == 4'hf) ? ~dq_in : d;
    byte_write_select_n = b;
    repeat (4) @(posedge clk);
    #1;
    k = kv;
    k_n = ~kv;
    c = single_clock ? 1'b0 : kv;
    c_n = single_clock ? 1'b0 : ~kv;
    repeat (6) @(posedge clk);
    #1;
  endtask
endmodule

`default_nettype wire

/* File: test_ddr2_sram_burst2_port.sv */
/*
  Self-checking bench for the burst SRAM port: reset values first, then a
  table of writes and reads, then idle, refused-load and clock enable cases.
  Assumes srb_ctrl_model drives the pins; expected data from a local model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "srb_params.svh"

module test_ddr2_sram_burst2_port;
  typedef struct packed {
    logic        rd;
    logic [19:0] a;
    logic [35:0] w0;
    logic [35:0] w1;
    logic [3:0]  b0;
    logic [3:0]  b1;
    logic        pll;
    logic        sgl;
  } srb_row_t;

  logic        clk;
  logic        reset;
  logic        ce;
  logic        pll_disable_n;
  logic        single_clock;
  logic        k;
  logic        k_n;
  logic        c;
  logic        c_n;
  logic        load_n;
  logic        rw;
  logic [19:0] addr;
  logic [3:0]  byte_write_select_n;
  logic [35:0] dq_in;
  logic [35:0] dq_out;
  logic        dq_oe;
  logic        echo_strobe;
  logic        echo_strobe_n;
  int          n_errors;
  int          checks_done;
  int          cycles;
  logic [35:0] mem [logic [19:0]];
  srb_row_t    rows [8];

  srb_ctrl_model srb_ctrl_model_i (.clk(clk), .single_clock(single_clock), .k(k),
    .k_n(k_n), .c(c), .c_n(c_n), .load_n(load_n), .rw(rw), .addr(addr),
    .byte_write_select_n(byte_write_select_n), .dq_in(dq_in));

  srb_port srb_port_i (.clk(clk), .reset(reset), .ce(ce), .k_in(k), .k_n_in(k_n),
    .c_in(c), .c_n_in(c_n), .load_n(load_n), .rw(rw), .pll_disable_n(pll_disable_n),
    .single_clock(single_clock), .addr(addr), .byte_write_select_n(byte_write_select_n),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .echo_strobe(echo_strobe),
    .echo_strobe_n(echo_strobe_n));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] d,
                                        input logic [3:0] b);
    merge = old;
    for (int n = 0; n < 4; n++)
      if (!b[n])
        merge[9*n +: 9] = d[9*n +: 9];
  endfunction

  // A low mid_lstb asks for a new load in mid-burst, which must be refused
  task automatic wr(input srb_row_t r, input logic mid_lstb);
    srb_ctrl_model_i.phase(1'b1, 1'b0, 1'b0, r.a, 36'h0, 4'hf);
    srb_ctrl_model_i.phase(1'b0, 1'b1, 1'b0, r.a, 36'h0, 4'hf);
    srb_ctrl_model_i.phase(1'b1, mid_lstb, 1'b1, r.a, r.w0, r.b0);
    srb_ctrl_model_i.phase(1'b0, 1'b1, 1'b1, r.a, r.w1, r.b1);
    // A frozen port stores nothing, so the local copy stays as it is
    if (ce)
    begin
      mem[r.a] = merge(mem[r.a], r.w0, r.b0);
      mem[r.a ^ 20'h1] = merge(mem[r.a ^ 20'h1], r.w1, r.b1);
    end
  endtask

  task automatic rd(input srb_row_t r);
    int   f;
    logic kv;
    pll_disable_n = r.pll;
    single_clock = r.sgl;
    f = r.pll ? 1 : 2;
    srb_ctrl_model_i.phase(1'b1, 1'b0, 1'b1, r.a, 36'h0, 4'hf);
    for (int s = 1; s <= 4; s++)
    begin
      kv = ~s[0];
      srb_ctrl_model_i.phase(kv, 1'b1, 1'b1, r.a, 36'h0, 4'hf);
      check(36'(dq_oe), 36'(s == f || s == f + 1));
      if (s == f)
        check(dq_out, mem[r.a]);
      if (s == f + 1)
        check(dq_out, mem[r.a ^ 20'h1]);
      check(36'({echo_strobe, echo_strobe_n}), 36'({kv, ~kv}));
    end
    srb_ctrl_model_i.phase(1'b0, 1'b1, 1'b1, r.a, 36'h0, 4'hf);
  endtask

  task automatic idle(input logic lstb);
    for (int s = 1; s <= 4; s++)
    begin
      srb_ctrl_model_i.phase(s[0], lstb, 1'b1, 20'h00010, 36'h0, 4'hf);
      check(36'(dq_oe), 36'h0);
    end
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      $display("FAIL %0t run timed out", $time);
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset = 1'b1;
    ce = 1'b1;
    pll_disable_n = 1'b1;
    single_clock = 1'b0;
    n_errors = 0;
    checks_done = 0;
    cycles = 0;
    rows[0] = '{1'b0, 20'h00010, 36'h1_2345_6789, 36'h9_8765_4321, 4'h0, 4'h0, 1'b1, 1'b0};
    rows[1] = '{1'b0, 20'h00021, 36'ha_aaaa_aaaa, 36'h5_5555_5555, 4'h0, 4'h0, 1'b1, 1'b0};
    rows[2] = '{1'b1, 20'h00010, 36'h0, 36'h0, 4'hf, 4'hf, 1'b1, 1'b0};
    rows[3] = '{1'b1, 20'h00021, 36'h0, 36'h0, 4'hf, 4'hf, 1'b0, 1'b0};
    rows[4] = '{1'b0, 20'h00010, 36'hc_3c3c_3c3c, 36'h3_c3c3_c3c3, 4'h5, 4'ha, 1'b1, 1'b0};
    rows[5] = '{1'b1, 20'h00011, 36'h0, 36'h0, 4'hf, 4'hf, 1'b1, 1'b1};
    rows[6] = '{1'b0, 20'h00021, 36'h0, 36'h0, 4'hf, 4'hf, 1'b1, 1'b0};
    rows[7] = '{1'b1, 20'h00020, 36'h0, 36'h0, 4'hf, 4'hf, 1'b0, 1'b1};
    repeat (5) @(posedge clk);
    #1;
    check(36'({dq_oe, echo_strobe, echo_strobe_n}), 36'h0);
    check(dq_out, 36'h0);
    repeat (5) @(posedge clk);
    #1;
    reset = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      if (rows[i].rd)
        rd(rows[i]);
      else
        wr(rows[i], 1'b1);
      $display("test %0d done", i);
    end
    // A true edge with the load strobe high must start nothing
    idle(1'b1);
    $display("test idle done");
    // Load attempt during a write burst is dropped; the write still lands
    wr('{1'b0, 20'h00031, 36'h7_0f0f_0f0f, 36'h0_1234_abcd, 4'h0, 4'h0, 1'b1, 1'b0}, 1'b0);
    idle(1'b1);
    rd('{1'b1, 20'h00030, 36'h0, 36'h0, 4'hf, 4'hf, 1'b1, 1'b0});
    $display("test refused load done");
    // Clock enable low freezes the port: a whole write must leave no trace
    ce = 1'b0;
    wr('{1'b0, 20'h00010, 36'h0, 36'h0, 4'h0, 4'h0, 1'b1, 1'b0}, 1'b1);
    check(36'(dq_oe), 36'h0);
    ce = 1'b1;
    rd(rows[2]);
    $display("test clock enable done");
    end_sim();
  end
endmodule

`default_nettype wire
